/* File: verilog/mon_regs_pkg.sv */
/*
 * Constants and carrier types for the hardware-monitor control and status bank.
 * Assumes a single 100 MHz clock and a simple strobed register port.
 */
package mon_regs_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_CHAN_MODE = 8'h16;
	localparam logic [7:0] ADDR_CONFIG_ONE = 8'h40;
	localparam logic [7:0] ADDR_IRQ_STATUS_ONE = 8'h41;
	localparam logic [7:0] ADDR_IRQ_STATUS_TWO = 8'h42;
	localparam logic [7:0] ADDR_IRQ_MASK_ONE = 8'h43;
	localparam logic [7:0] ADDR_IRQ_MASK_TWO = 8'h44;
	// Reset values
	localparam logic [7:0] RST_CHAN_MODE = 8'h00;
	localparam logic [7:0] RST_CONFIG_ONE = 8'h08;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	// Channel-mode field positions
	localparam int CM_MULTI_A = 0;
	localparam int CM_MULTI_B = 1;
	localparam int CM_DIODE_TWO = 2;
	localparam int CM_SUPPLY_RANGE = 3;
	localparam int CM_IRQ_EN_LO = 4;
	localparam int CM_VOLTAGE_ID_OR_IRQ_SELECT = 7;
	// Config-one field positions
	localparam int CF_RUN = 0;
	localparam int CF_INT_EN = 1;
	localparam int CF_THERMAL_ALARM_PIN_EN = 2;
	localparam int CF_INT_CLEAR = 3;
	localparam int CF_RESET = 4;
	localparam int CF_THERMAL_ALARM_CLEAR = 6;
	localparam int CF_INIT = 7;
	// Status-two field positions
	localparam int ST2_CHASSIS = 4;
	localparam int ST2_THERMAL_ALARM_PIN_PIN = 5;
	localparam int ST2_DIODE_LO = 6;
	// Bits of status two that exist; 2 and 3 read zero
	localparam logic [7:0] ST2_USED = 8'hF3;
	// Reset pulse length
	localparam int RST_PULSE_MS = 45;
	localparam int CLK_MHZ = 100;
	localparam int RST_PULSE_CYCLES = RST_PULSE_MS * CLK_MHZ * 1000;
	localparam int RST_CNT_W = 23;
	// Reset pulse sequencer, one-hot
	typedef enum logic [1:0] {
		RP_IDLE = 2'b01,
		RP_PULSE = 2'b10
	} rst_pulse_e;
	// One register-port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;
endpackage : mon_regs_pkg

/* File: verilog/monitor_config_and_irq_status.sv */
/*
 * Control and status register bank of a system hardware monitor: channel
 * mode, run and interrupt control, sticky status with read-clear, masks,
 * interrupt, thermal alarm and timed reset outputs.
 * Assumes the measurement engine runs on the same clock and reports
 * limit, temperature and diode events as levels; pins are asynchronous.
 */
//
// Overview of operation
// - Mode bit 0: input A tach or analog
// - Mode bit 1: input B tach or analog
// - Mode bit 2: supplies or second diode
// - Mode bit 3: supply range 3.3/5 V
// - Mode bits 4-6 enable interrupt pins
// - Mode bit 7: voltage-ID or interrupt pins
// - Config bit 0 runs or stands by
// - Stopping run keeps interrupt asserted
// - Config bit 1 gates interrupt output
// - Config bit 3 clears interrupt, pauses monitoring
// - Config bit 4 gives 45 ms reset
// - Config bit 6 clears thermal alarm
// - Config bit 7 restores config, status and mask defaults; mode is kept
// - Status one flags per-channel limit errors
// - Temperature interrupts also set status bits
// - Status two: 12 V, core two
// - Status two bit 4: chassis intrusion
// - Status two bit 5: thermal pin pulled
// - Status two bits 6-7: diode faults
// - Status read clears bits read
// - Mask bit blocks its status bit
`timescale 1ns/1ns
module monitor_config_and_irq_status #(
	parameter int unsigned RstPulseCycles = mon_regs_pkg::RST_PULSE_CYCLES
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire mon_regs_pkg::bus_req_s busReq,
	output logic [7:0] rdData,
	input wire logic [7:0] limitHitOne,
	input wire logic [1:0] limitHitTwo,
	input wire logic [1:0] tempIrq,
	input wire logic tempAlarm,
	input wire logic [1:0] diodeFault,
	input wire logic chassisPin,
	input wire logic thermalAlarmPinIn,
	output logic thermalAlarmPinOut,
	output logic thermalAlarmPinOe,
	input wire logic [4:0] voltageIdPins,
	output logic [4:0] voltageIdInputs,
	output logic intOutN,
	output logic resetOutN,
	output logic scanActive,
	output logic multiInputASelect,
	output logic multiInputBSelect,
	output logic diodeTwoSelect,
	output logic supplyRangeSelect,
	output logic voltageIdOrIrqSelect
);
	import mon_regs_pkg::*;

	// Registers
	logic [7:0] chanMode_q, chanMode_d; // Channel mode
	logic [7:0] cfgOne_q, cfgOne_d; // Config one, bits 4, 6 and 7 never held
	logic [7:0] stOne_q, stOne_d; // Sticky status one
	logic [7:0] stTwo_q, stTwo_d; // Sticky status two
	logic [7:0] maskOne_q, maskOne_d; // Interrupt mask one
	logic [7:0] maskTwo_q, maskTwo_d; // Interrupt mask two
	logic [7:0] rdData_q; // Read data, valid one cycle after strobe
	// Pin synchronisers, stage A read only by stage B
	logic [9:0] pinSyncA_q, pinSyncB_q;
	logic chassisPrev_q; // For rising-edge detection of intrusion
	logic thermLatch_q, thermLatch_d; // Thermal alarm drive
	logic [1:0] ownDrive_q; // Own drive, delayed to line up with the pin synchroniser
	logic intOutN_q; // Interrupt pin, active low
	logic extIrqAct_q; // Enabled interrupt pins active
	logic scanActive_q; // Monitoring running
	logic [4:0] vid_q; // Captured voltage-ID value
	rst_pulse_e rpState_q, rpState_d; // Reset pulse sequencer
	logic [RST_CNT_W-1:0] rpCnt_q, rpCnt_d; // Remaining low cycles
	logic resetOutN_q; // Reset pin

	// Decoded pin views
	wire chassisSync = pinSyncB_q[0];
	wire thermInSync = pinSyncB_q[1];
	wire [2:0] irqPinSync = pinSyncB_q[4:2];
	wire [4:0] vidSync = pinSyncB_q[9:5];

	// Address decode
	wire selMode = (busReq.addr == ADDR_CHAN_MODE);
	wire selCfg = (busReq.addr == ADDR_CONFIG_ONE);
	wire selSt1 = (busReq.addr == ADDR_IRQ_STATUS_ONE);
	wire selSt2 = (busReq.addr == ADDR_IRQ_STATUS_TWO);
	wire selM1 = (busReq.addr == ADDR_IRQ_MASK_ONE);
	wire selM2 = (busReq.addr == ADDR_IRQ_MASK_TWO);
	wire wrCfg = busReq.wr && selCfg;
	wire initReq = wrCfg && busReq.wdata[CF_INIT]; // Restore defaults
	wire thermClr = wrCfg && busReq.wdata[CF_THERMAL_ALARM_CLEAR]; // Thermal clear
	wire rstReq = wrCfg && busReq.wdata[CF_RESET]; // Start reset pulse

	// Monitoring runs only when started and not held by interrupt clear
	wire monActive = cfgOne_q[CF_RUN] && !cfgOne_q[CF_INT_CLEAR];

	// Status event sources; temperature interrupts join their limit bits
	wire [7:0] evOne = monActive
		? (limitHitOne | {2'b00, tempIrq, 4'h0}) : 8'h00;
	// Own drive stays masked until the synchroniser has caught up with the wire;
	// otherwise releasing the pin would look like an outside pull for two cycles
	wire extThermLow = !thermInSync && !thermLatch_q && (ownDrive_q == 2'b00);
	wire [7:0] evTwo = {diodeFault, extThermLow, chassisSync && !chassisPrev_q,
		2'b00, monActive ? limitHitTwo : 2'b00};

	// Read-clear strobes for the status registers
	wire rdSt1 = busReq.rd && selSt1;
	wire rdSt2 = busReq.rd && selSt2;

	// Read data selection; unmapped addresses read zero
	wire [7:0] rdMux = selMode ? chanMode_q
		: selCfg ? (cfgOne_q | {3'b000, (rpState_q == RP_PULSE), 4'h0})
		: selSt1 ? stOne_q
		: selSt2 ? (stTwo_q & ST2_USED)
		: selM1 ? maskOne_q
		: selM2 ? maskTwo_q
		: 8'h00;

	// Unmasked status and external interrupt pins feed the interrupt
	wire anyUnmasked = |(stOne_q & ~maskOne_q) || |(stTwo_q & ~maskTwo_q);
	wire [2:0] irqEn = chanMode_q[CM_IRQ_EN_LO+2:CM_IRQ_EN_LO];
	wire extIrqNow = chanMode_q[CM_VOLTAGE_ID_OR_IRQ_SELECT] && |(irqPinSync & irqEn);
	// Run bit plays no part, so stopping keeps the pin asserted
	wire intAssert = cfgOne_q[CF_INT_EN] && !cfgOne_q[CF_INT_CLEAR]
		&& (anyUnmasked || extIrqAct_q);

	// Channel mode register
	always_comb begin
		chanMode_d = chanMode_q;
		if (busReq.wr && selMode) begin
			chanMode_d = busReq.wdata;
		end
	end

	// Config one: init wins over everything and self-clears
	always_comb begin
		cfgOne_d = cfgOne_q;
		if (initReq) begin
			cfgOne_d = RST_CONFIG_ONE;
		end else if (wrCfg) begin
			// Reset, thermal clear and init are actions, not storage
			cfgOne_d = busReq.wdata & 8'h2F;
		end
	end

	// Sticky status: a new event in a read cycle survives the clear
	always_comb begin
		stOne_d = (rdSt1 ? 8'h00 : stOne_q) | evOne;
		stTwo_d = ((rdSt2 ? 8'h00 : stTwo_q) | evTwo) & ST2_USED;
		if (initReq) begin
			stOne_d = RST_STATUS;
			stTwo_d = RST_STATUS;
		end
	end

	// Masks
	always_comb begin
		maskOne_d = maskOne_q;
		maskTwo_d = maskTwo_q;
		if (initReq) begin
			maskOne_d = RST_MASK;
			maskTwo_d = RST_MASK;
		end else begin
			if (busReq.wr && selM1) begin
				maskOne_d = busReq.wdata;
			end
			if (busReq.wr && selM2) begin
				maskTwo_d = busReq.wdata;
			end
		end
	end

	// Thermal alarm latch; a new alarm beats a clear in the same cycle
	always_comb begin
		thermLatch_d = thermLatch_q;
		if (thermClr) begin
			thermLatch_d = 1'b0;
		end
		if (tempAlarm && cfgOne_q[CF_THERMAL_ALARM_PIN_EN]) begin
			thermLatch_d = 1'b1;
		end
	end

	// Reset pulse sequencer; a request during a pulse is ignored
	always_comb begin
		rpState_d = rpState_q;
		rpCnt_d = rpCnt_q;
		case (rpState_q)
			RP_IDLE: begin
				if (rstReq) begin
					rpState_d = RP_PULSE;
					rpCnt_d = RST_CNT_W'(RstPulseCycles - 1);
				end
			end
			RP_PULSE: begin
				if (rpCnt_q == '0) begin
					rpState_d = RP_IDLE;
				end else begin
					rpCnt_d = rpCnt_q - RST_CNT_W'(1);
				end
			end
			default: begin
				rpState_d = RP_IDLE;
			end
		endcase
	end

	// Register state
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			chanMode_q <= RST_CHAN_MODE;
			cfgOne_q <= RST_CONFIG_ONE;
			stOne_q <= RST_STATUS;
			stTwo_q <= RST_STATUS;
			maskOne_q <= RST_MASK;
			maskTwo_q <= RST_MASK;
			rdData_q <= 8'h00;
		end else begin
			chanMode_q <= chanMode_d;
			cfgOne_q <= cfgOne_d;
			stOne_q <= stOne_d;
			stTwo_q <= stTwo_d;
			maskOne_q <= maskOne_d;
			maskTwo_q <= maskTwo_d;
			rdData_q <= busReq.rd ? rdMux : 8'h00;
		end
	end

	// Two-stage pin synchronisers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// Thermal wire idles high under its pull-up; zero here would flag a false pull
			pinSyncA_q <= 10'h002;
			pinSyncB_q <= 10'h002;
			chassisPrev_q <= 1'b0;
			ownDrive_q <= 2'b00;
		end else begin
			pinSyncA_q <= {voltageIdPins, irqPinsFromVid(voltageIdPins), thermalAlarmPinIn,
				chassisPin};
			pinSyncB_q <= pinSyncA_q;
			chassisPrev_q <= chassisSync;
			ownDrive_q <= {ownDrive_q[0], thermLatch_q};
		end
	end

	// The three interrupt pins share the voltage-ID group, top three pins
	function automatic logic [2:0] irqPinsFromVid(input logic [4:0] pins);
		irqPinsFromVid = {pins[2], pins[3], pins[4]};
	endfunction : irqPinsFromVid

	// Output drivers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			thermLatch_q <= 1'b0;
			intOutN_q <= 1'b1;
			extIrqAct_q <= 1'b0;
			scanActive_q <= 1'b0;
			vid_q <= 5'h00;
			rpState_q <= RP_IDLE;
			rpCnt_q <= '0;
			resetOutN_q <= 1'b1;
		end else begin
			thermLatch_q <= thermLatch_d;
			intOutN_q <= !intAssert;
			extIrqAct_q <= extIrqNow;
			scanActive_q <= monActive;
			// Voltage-ID value is only meaningful in ID mode
			vid_q <= chanMode_q[CM_VOLTAGE_ID_OR_IRQ_SELECT] ? 5'h00 : vidSync;
			rpState_q <= rpState_d;
			rpCnt_q <= rpCnt_d;
			resetOutN_q <= (rpState_d != RP_PULSE);
		end
	end

	assign rdData = rdData_q;
	assign thermalAlarmPinOut = 1'b0; // Open drain: only ever pulls low
	assign thermalAlarmPinOe = thermLatch_q;
	assign voltageIdInputs = vid_q;
	assign intOutN = intOutN_q;
	assign resetOutN = resetOutN_q;
	assign scanActive = scanActive_q;
	assign multiInputASelect = chanMode_q[CM_MULTI_A];
	assign multiInputBSelect = chanMode_q[CM_MULTI_B];
	assign diodeTwoSelect = chanMode_q[CM_DIODE_TWO];
	assign supplyRangeSelect = chanMode_q[CM_SUPPLY_RANGE];
	assign voltageIdOrIrqSelect = chanMode_q[CM_VOLTAGE_ID_OR_IRQ_SELECT];

	// Helper: cycles the reset pin has stayed low, cleared while it is high
	logic [RST_CNT_W:0] lowCnt_q;
	always_ff @(posedge clock) begin
		if (sys_rst || resetOutN_q) begin
			lowCnt_q <= '0;
		end else begin
			lowCnt_q <= lowCnt_q + (RST_CNT_W+1)'(1);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	// Config write carrying a given bit pattern
	sequence cfgWrite(logic [7:0] m, logic [7:0] v);
		busReq.wr && selCfg && ((busReq.wdata & m) == v);
	endsequence
	sequence modeWrite;
		busReq.wr && selMode;
	endsequence

	a_mode_inputs: assert property (modeWrite |=>
		{supplyRangeSelect, diodeTwoSelect, multiInputBSelect, multiInputASelect}
		== $past(busReq.wdata[3:0]))
		else $error("channel mode outputs wrong");
	a_irq_gate: assert property (!voltageIdOrIrqSelect |=> !extIrqAct_q)
		else $error("interrupt pins active in ID mode");
	a_run_start: assert property (cfgWrite(8'h89, 8'h01) |=> ##1 scanActive)
		else $error("scanning did not start");
	a_int_hold: assert property (cfgWrite(8'h8B, 8'h02) ##0 (!intOutN && !busReq.rd
		&& !extIrqAct_q && anyUnmasked) |=> ##1 !intOutN)
		else $error("stopping run released interrupt");
	a_int_clear: assert property (cfgWrite(8'h88, 8'h08) |=> ##1 (intOutN
		&& !scanActive))
		else $error("interrupt clear not honoured");
	a_int_assert: assert property (cfgOne_q[CF_INT_EN] && !cfgOne_q[CF_INT_CLEAR]
		&& |(stOne_q & ~maskOne_q) |=> !intOutN)
		else $error("unmasked status did not interrupt");
	a_int_gate: assert property (!cfgOne_q[CF_INT_EN] |=> intOutN)
		else $error("disabled interrupt asserted");
	a_mask_block: assert property (stTwo_q == 8'h00 && !extIrqAct_q
		&& (stOne_q & ~maskOne_q) == 8'h00 |=> intOutN)
		else $error("masked status interrupted");
	a_reset_pulse: assert property ($rose(resetOutN) |->
		lowCnt_q == (RST_CNT_W+1)'(RstPulseCycles))
		else $error("reset pulse length wrong");
	a_reset_start: assert property (cfgWrite(8'h90, 8'h10) ##0 rpState_q == RP_IDLE
		|=> !resetOutN [*2])
		else $error("reset pulse not started");
	a_thermal_alarm_pin_clear: assert property (cfgWrite(8'h40, 8'h40) ##0 !tempAlarm
		|=> !thermalAlarmPinOe)
		else $error("thermal clear failed");
	a_init_defaults: assert property (cfgWrite(8'h80, 8'h80) |=> cfgOne_q == RST_CONFIG_ONE
		&& maskOne_q == RST_MASK && maskTwo_q == RST_MASK)
		else $error("init did not restore defaults");
	a_read_clear: assert property (rdSt1 && !monActive |=> stOne_q == 8'h00)
		else $error("status one not cleared by read");
	a_chassis_flag: assert property (chassisSync && !chassisPrev_q && !initReq
		|=> stTwo_q[ST2_CHASSIS])
		else $error("chassis event lost");
	a_diode_flag: assert property (diodeFault[0] && !initReq |=> stTwo_q[ST2_DIODE_LO])
		else $error("diode fault lost");
	a_read_data: assert property (busReq.rd && selMode |=> rdData == $past(chanMode_q))
		else $error("read data wrong");
	// Monitoring halted means the scan indicator drops on the next edge
	a_scan_gate: assert property (!monActive |=> !scanActive)
		else $error("scanning while stopped or paused");
	// While paused no limit or temperature event may reach status one
	a_paused_quiet: assert property (!monActive && !rdSt1 && !initReq
		|=> stOne_q == $past(stOne_q))
		else $error("status one changed while paused");
	// Interrupt mode forces the voltage-ID view to zero
	a_vid_zero: assert property (voltageIdOrIrqSelect |=> voltageIdInputs == 5'h00)
		else $error("voltage ID shown in interrupt mode");
	// A low wire that is not our own drive raises the thermal flag
	a_thermal_alarm_pin_flag: assert property (!thermInSync && !thermLatch_q && ownDrive_q == 2'b00
		&& !initReq |=> stTwo_q[ST2_THERMAL_ALARM_PIN_PIN])
		else $error("external thermal pull lost");
	// Our own drive, and its echo through the synchroniser, never sets the flag
	a_thermal_alarm_pin_own: assert property ((thermLatch_q || ownDrive_q != 2'b00) && !rdSt2
		&& !initReq |=> stTwo_q[ST2_THERMAL_ALARM_PIN_PIN] == $past(stTwo_q[ST2_THERMAL_ALARM_PIN_PIN]))
		else $error("own thermal drive flagged as external");
endmodule : monitor_config_and_irq_status

/* File: tb/thermal_alarm_pin_pin_env.sv */
/*
 * Far-side model of the open-drain thermal alarm wire: a pull-up, the
 * bank's own driver and an outside source that may pull the wire low.
 * Assumes the bank drives only while its output enable is high.
 */
`timescale 1ns/1ns
module thermal_alarm_pin_pin_env (
	input wire logic dutOut, // Level the bank would drive
	input wire logic dutOe, // High while the bank pulls the wire
	input wire logic extPull, // High while the outside source pulls low
	output logic pinLevel // Resolved wire level seen by everyone
);
	// Pull-up wins only when nobody drives; an outside pull is the event to flag
	assign pinLevel = !extPull && (dutOe ? dutOut : 1'b1);
endmodule : thermal_alarm_pin_pin_env

/* File: tb/monitor_config_and_irq_status_tb.sv */
/*
 * Directed bench for the monitor control and status bank: register port
 * tasks, pin stimulus and expected values from the register table.
 * Assumes one 100 MHz clock and a reset pulse shortened to 20 cycles.
 */
`timescale 1ns/1ns
module monitor_config_and_irq_status_tb;
	import mon_regs_pkg::*;
	localparam int PulseLen = 20; // Short pulse keeps the run brief
	localparam logic [7:0] RegAddr [7] = '{8'h16, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h3E};
	localparam logic [7:0] RegRst [7] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic clock = 1'b0;
	logic sys_rst = 1'b1; // Held for four edges at start
	bus_req_s busReq = '0;
	logic [7:0] rdData;
	logic [7:0] limitHitOne = 8'h00;
	logic [1:0] limitHitTwo = 2'b00;
	logic [1:0] tempIrq = 2'b00;
	logic [1:0] diodeFault = 2'b00;
	logic tempAlarm = 1'b0;
	logic chassisPin = 1'b0;
	logic extPull = 1'b0; // Outside source pulling the thermal wire
	logic [4:0] voltageIdPins = 5'h15; // Bit 4 high doubles as interrupt pin a
	logic thermPin, thermOut, thermOe, intOutN, resetOutN, scanActive;
	logic selA, selB, selDiode, selRange, selVid;
	logic [4:0] vidOut;
	int err_count = 0;
	int checked = 0;

	// Free-running 100 MHz clock
	always #5 clock = ~clock;

	monitor_config_and_irq_status #(.RstPulseCycles(PulseLen)) i_dut (
		.clock(clock), .sys_rst(sys_rst), .busReq(busReq), .rdData(rdData),
		.limitHitOne(limitHitOne), .limitHitTwo(limitHitTwo), .tempIrq(tempIrq),
		.tempAlarm(tempAlarm), .diodeFault(diodeFault), .chassisPin(chassisPin),
		.thermalAlarmPinIn(thermPin), .thermalAlarmPinOut(thermOut),
		.thermalAlarmPinOe(thermOe), .voltageIdPins(voltageIdPins),
		.voltageIdInputs(vidOut), .intOutN(intOutN), .resetOutN(resetOutN),
		.scanActive(scanActive), .multiInputASelect(selA), .multiInputBSelect(selB),
		.diodeTwoSelect(selDiode), .supplyRangeSelect(selRange),
		.voltageIdOrIrqSelect(selVid)
	);

	thermal_alarm_pin_pin_env i_env (.dutOut(thermOut), .dutOe(thermOe), .extPull(extPull),
		.pinLevel(thermPin));

	// Single comparison point; case inequality so unknowns never match
	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		busReq.wr <= 1'b0;
	endtask : wr

	// One-cycle read strobe; data stand only in the following cycle
	task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		busReq.rd <= 1'b0;
		#1 chk(what, rdData, e);
	endtask : rdChk

	// Let n edges pass, then sample settled outputs
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	// Prints counts and verdict, then stops
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// Watchdog: the tests need well under a thousand cycles
	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		int n;
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		foreach (RegAddr[i]) rdChk("reset value", RegAddr[i], RegRst[i]);
		wr(8'h3E, 8'hFF); // Unmapped place must ignore the write
		rdChk("unmapped", 8'h3E, 8'h00);
		// Mode selects follow the register straight away
		wr(ADDR_CHAN_MODE, 8'h0F);
		tick(3);
		chk("selects", {3'h0, selVid, selRange, selDiode, selB, selA}, 8'h0F);
		chk("vid mode", 8'(vidOut), 8'h15);
		// Interrupt pin group: bit 7 alone does nothing without an enable bit
		wr(ADDR_CHAN_MODE, 8'h80);
		wr(ADDR_CONFIG_ONE, 8'h02);
		tick(3);
		chk("irq pins off", 8'(intOutN), 8'h01);
		chk("vid in irq mode", 8'(vidOut), 8'h00);
		wr(ADDR_CHAN_MODE, 8'h90);
		tick(3);
		chk("irq pin a", 8'(intOutN), 8'h00);
		wr(ADDR_CHAN_MODE, 8'h00);
		wr(ADDR_IRQ_MASK_ONE, 8'h01); // Masks set before run is switched on
		wr(ADDR_CONFIG_ONE, 8'h03);
		tick(1);
		chk("scan on", 8'(scanActive), 8'h01);
		// Masked event sets status but leaves the interrupt quiet
		@(posedge clock) limitHitOne <= 8'h01;
		@(posedge clock) limitHitOne <= 8'h00;
		tick(3);
		chk("masked", 8'(intOutN), 8'h01);
		rdChk("status one", ADDR_IRQ_STATUS_ONE, 8'h01);
		@(posedge clock) limitHitOne <= 8'h80;
		@(posedge clock) limitHitOne <= 8'h00;
		tick(3);
		chk("unmasked", 8'(intOutN), 8'h00);
		// Stopping the run must not release the interrupt
		wr(ADDR_CONFIG_ONE, 8'h02);
		tick(2);
		chk("run off keeps int", 8'(intOutN), 8'h00);
		chk("scan off", 8'(scanActive), 8'h00);
		wr(ADDR_CONFIG_ONE, 8'h0A);
		tick(2);
		chk("int clear", 8'(intOutN), 8'h01);
		@(posedge clock) limitHitOne <= 8'h02; // Ignored while paused
		@(posedge clock) limitHitOne <= 8'h00;
		rdChk("status kept", ADDR_IRQ_STATUS_ONE, 8'h80);
		rdChk("read cleared", ADDR_IRQ_STATUS_ONE, 8'h00);
		wr(ADDR_CONFIG_ONE, 8'h03);
		@(posedge clock) tempIrq <= 2'b11;
		@(posedge clock) tempIrq <= 2'b00;
		rdChk("temp irq", ADDR_IRQ_STATUS_ONE, 8'h30);
		// Status two sources together; chassis pin stays high after its edge
		@(posedge clock) begin
			limitHitTwo <= 2'b11;
			diodeFault <= 2'b11;
			chassisPin <= 1'b1;
			extPull <= 1'b1;
		end
		@(posedge clock) limitHitTwo <= 2'b00;
		tick(5);
		@(posedge clock) begin
			diodeFault <= 2'b00;
			extPull <= 1'b0;
		end
		tick(5);
		rdChk("status two", ADDR_IRQ_STATUS_TWO, 8'hF3);
		rdChk("status two cleared", ADDR_IRQ_STATUS_TWO, 8'h00);
		// Thermal alarm drive, its clear, and its enable
		wr(ADDR_CONFIG_ONE, 8'h07);
		@(posedge clock) tempAlarm <= 1'b1;
		@(posedge clock) tempAlarm <= 1'b0;
		tick(1);
		chk("thermal_alarm_pin drive", 8'(thermOe), 8'h01);
		wr(ADDR_CONFIG_ONE, 8'h47);
		tick(1);
		chk("thermal_alarm_pin clear", 8'(thermOe), 8'h00);
		rdChk("thermal_alarm_pin status", ADDR_IRQ_STATUS_TWO, 8'h00);
		wr(ADDR_CONFIG_ONE, 8'h03);
		@(posedge clock) tempAlarm <= 1'b1;
		@(posedge clock) tempAlarm <= 1'b0;
		tick(1);
		chk("thermal_alarm_pin gated", 8'(thermOe), 8'h00);
		// Initialisation restores config and masks, mode stays
		wr(ADDR_CHAN_MODE, 8'h0A);
		wr(ADDR_IRQ_MASK_TWO, 8'hFF);
		wr(ADDR_CONFIG_ONE, 8'h80);
		rdChk("init config", ADDR_CONFIG_ONE, 8'h08);
		rdChk("init mask one", ADDR_IRQ_MASK_ONE, 8'h00);
		rdChk("init mask two", ADDR_IRQ_MASK_TWO, 8'h00);
		rdChk("mode kept", ADDR_CHAN_MODE, 8'h0A);
		// Timed reset pulse, low from the cycle after the write
		wr(ADDR_CONFIG_ONE, 8'h10);
		#1 chk("pulse start", 8'(resetOutN), 8'h00);
		n = 0;
		while (resetOutN === 1'b0 && n < 100) begin
			@(posedge clock);
			#1 n++;
		end
		chk("pulse length", 8'(n), 8'(PulseLen));
		rdChk("self clear", ADDR_CONFIG_ONE, 8'h00);
		tally_and_finish();
	end
endmodule : monitor_config_and_irq_status_tb
